// ### hdl/uart_serial_datapath.sv
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module uart_serial_datapath (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output wire logic        hreadyout,
  output wire logic        hresp,
  output logic      [31:0] hrdata,
  output wire logic        irq,
  input  wire logic        timer_tick_a,
  input  wire logic        timer_tick_b,
  input  wire logic        serial_in_pin_a,
  input  wire logic        serial_in_pin_b,
  output wire logic        serial_out_pin_a,
  output wire logic        serial_out_pin_b,
  output wire logic        serial_out_oe_n_a,
  output wire logic        serial_out_oe_n_b,
  input  wire logic        serial_clock_pin_a_in,
  input  wire logic        serial_clock_pin_b_in,
  output wire logic        serial_clock_pin_a_out,
  output wire logic        serial_clock_pin_b_out,
  output wire logic        serial_clock_pin_a_oe_n,
  output wire logic        serial_clock_pin_b_oe_n
);
  import uart_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic        wr_reg;
  logic [6:0]  waddr_reg;
  logic        rd_acc;
  logic [6:0]  raddr;
  logic       [31:0] ch_rdata [2];
  wire  logic [IRQ_W-1:0] ev;
  wire  logic [1:0] sin_pin, sck_pin, tmr, sout_w, sout_oe_w, sck_w, sck_oe_w;
  logic [IRQ_W-1:0] ist_reg, ien_reg, iclr;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_acc    = hsel & htrans[1] & hready & ~hwrite;
  assign raddr     = haddr[6:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg    <= 1'b0;
      waddr_reg <= 7'h00;
    end else begin
      wr_reg    <= hsel & htrans[1] & hready & hwrite;
      waddr_reg <= haddr[6:0];
    end
  end

  // Read data registered at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_acc) begin
      if (!raddr[GLB_SEL]) begin
        hrdata <= ch_rdata[raddr[CH_SEL]];
      end else if (raddr[4:0] == OFF_IST) begin
        hrdata <= {26'h0, ist_reg};
      end else if (raddr[4:0] == OFF_IEN) begin
        hrdata <= {26'h0, ien_reg};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt collection

  assign iclr = (wr_reg & waddr_reg[GLB_SEL] & (waddr_reg[4:0] == OFF_ICLR)) ?
                hwdata[IRQ_W-1:0] : '0;

  // New events win over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ist_reg <= '0;
    end else begin
      ist_reg <= (ist_reg & ~iclr) | ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ien_reg <= '0;
    end else if (wr_reg & waddr_reg[GLB_SEL] & (waddr_reg[4:0] == OFF_IEN)) begin
      ien_reg <= hwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(ist_reg & ien_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Pin mapping

  assign sin_pin = {serial_in_pin_b, serial_in_pin_a};
  assign sck_pin = {serial_clock_pin_b_in, serial_clock_pin_a_in};
  assign tmr     = {timer_tick_b, timer_tick_a};
  assign serial_out_pin_a        = sout_w[0];
  assign serial_out_pin_b        = sout_w[1];
  assign serial_out_oe_n_a       = sout_oe_w[0];
  assign serial_out_oe_n_b       = sout_oe_w[1];
  assign serial_clock_pin_a_out  = sck_w[0];
  assign serial_clock_pin_b_out  = sck_w[1];
  assign serial_clock_pin_a_oe_n = sck_oe_w[0];
  assign serial_clock_pin_b_oe_n = sck_oe_w[1];

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar c = 0; c < 2; c++) begin : g_ch
    uart_ch_if   chi ();
    logic [1:0]  sin_s, sck_s;
    logic        sck_prev, ext_tick, brg_tick, we, re_rxd, eclr;
    logic [15:0] brg_cnt;
    logic [5:0]  mode_reg;
    logic [7:0]  ctrl_reg;
    logic [2:0]  baud_reg, sten_reg;
    logic [7:0]  txd_reg, rxd_reg;
    logic        tx_full, rx_full, rxad_reg, perr_reg, ovr_reg, ferr_reg;
    logic [4:0]  woff;

    assign woff   = waddr_reg[4:0];
    assign we     = wr_reg & ~waddr_reg[GLB_SEL] & (waddr_reg[CH_SEL] == c);
    assign re_rxd = rd_acc & ~raddr[GLB_SEL] & (raddr[CH_SEL] == c) &
                    (raddr[4:0] == OFF_RXD);

    // Pin synchronisers
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sin_s    <= 2'b11;
        sck_s    <= 2'b11;
        sck_prev <= 1'b1;
      end else begin
        sin_s    <= {sin_s[0], sin_pin[c]};
        sck_s    <= {sck_s[0], sck_pin[c]};
        sck_prev <= sck_s[1];
      end
    end
    assign ext_tick = sck_s[1] & ~sck_prev;

    // Dedicated baud generator
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        brg_cnt <= 16'h0000;
      end else if (brg_cnt == 16'h0000) begin
        brg_cnt <= (BRG_BASE << baud_reg) - 16'h0001;
      end else begin
        brg_cnt <= brg_cnt - 16'h0001;
      end
    end
    assign brg_tick = (brg_cnt == 16'h0000);

    always_comb begin
      unique case (src_t'(mode_reg[MD_SRC +: 2]))
        SRC_BRG:   chi.tick = brg_tick;
        SRC_EXT:   chi.tick = ext_tick;
        SRC_TIMER: chi.tick = tmr[c];
        SRC_NONE:  chi.tick = 1'b0;
      endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        mode_reg <= MODE_RST;
      end else if (we & (woff == OFF_MODE)) begin
        mode_reg <= hwdata[5:0];
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ctrl_reg <= CTRL_RST;
      end else if (we & (woff == OFF_CTRL)) begin
        ctrl_reg <= hwdata[7:0] & ~(8'h01 << CT_ECLR);
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sten_reg <= 3'h0;
        baud_reg <= BAUD_RST;
      end else begin
        if (we & (woff == OFF_STAT)) begin
          sten_reg <= hwdata[ST_RIE:ST_MSB];
        end
        if (we & (woff == OFF_BAUD)) begin
          baud_reg <= hwdata[2:0];
        end
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        txd_reg <= 8'h00;
        tx_full <= 1'b0;
      end else if (we & (woff == OFF_TXD)) begin
        txd_reg <= hwdata[7:0];
        tx_full <= 1'b1;
      end else if (chi.tx_start) begin
        tx_full <= 1'b0;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        rxd_reg  <= 8'h00;
        rxad_reg <= 1'b0;
        rx_full  <= 1'b0;
      end else if (chi.rx_done) begin
        rxd_reg  <= chi.rx_data;
        rxad_reg <= chi.rx_ad;
        rx_full  <= 1'b1;
      end else if (re_rxd) begin
        rx_full <= 1'b0;
      end
    end

    assign eclr = we & (woff == OFF_CTRL) & hwdata[CT_ECLR];

    // sticky errors, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        perr_reg <= 1'b0;
        ferr_reg <= 1'b0;
        ovr_reg  <= 1'b0;
      end else begin
        perr_reg <= (perr_reg & ~eclr) | (chi.rx_done & chi.rx_perr);
        ferr_reg <= (ferr_reg & ~eclr) | (chi.rx_done & chi.rx_ferr);
        ovr_reg  <= (ovr_reg & ~eclr) | (chi.rx_done & rx_full & ~re_rxd);
      end
    end

    always_comb begin
      unique case (raddr[4:0])
        OFF_MODE: ch_rdata[c] = {26'h0, mode_reg};
        OFF_CTRL: ch_rdata[c] = {24'h0, ctrl_reg};
        OFF_STAT: ch_rdata[c] = {23'h0, sten_reg, chi.tx_busy, ferr_reg, ovr_reg,
                                 perr_reg, rx_full, ~tx_full};
        OFF_RXD:  ch_rdata[c] = {23'h0, rxad_reg, rxd_reg};
        OFF_BAUD: ch_rdata[c] = {29'h0, baud_reg};
        default:  ch_rdata[c] = 32'h0000_0000;
      endcase
    end

    assign chi.mode      = mode_t'(mode_reg[MD_MODE +: 2]);
    assign chi.par_en    = ctrl_reg[CT_PEN];
    assign chi.par_odd   = ctrl_reg[CT_PODD];
    assign chi.two_stop  = ctrl_reg[CT_STP2];
    assign chi.eight     = ctrl_reg[CT_BIT8];
    assign chi.tx_ad     = ctrl_reg[CT_AD];
    assign chi.rx_en     = ctrl_reg[CT_RXE];
    assign chi.msb_first = sten_reg[0];
    assign chi.tx_data   = txd_reg;
    assign chi.tx_start  = tx_full & ctrl_reg[CT_TXE] & ~chi.tx_busy;
    assign chi.sin       = sin_s[1];

    assign ev[c*IRQ_PER]     = chi.rx_done & sten_reg[2];
    assign ev[c*IRQ_PER + 1] = chi.rx_done & sten_reg[2] &
                               (chi.rx_perr | chi.rx_ferr | (rx_full & ~re_rxd));
    assign ev[c*IRQ_PER + 2] = chi.tx_done & sten_reg[1];

    assign sout_w[c]    = chi.sout;
    assign sout_oe_w[c] = ~mode_reg[MD_SOE];
    assign sck_w[c]     = chi.sck_lvl;
    assign sck_oe_w[c]  = ~mode_reg[MD_SCKO];

    uart_tx u_tx (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ch      (chi.tx)
    );

    uart_rx u_rx (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ch      (chi.rx)
    );
  end

endmodule // uart_serial_datapath
`default_nettype wire

// ### hdl/uart_pkg.sv
package uart_pkg;
  // Byte offsets within a channel, channel b at +0x20
  localparam logic [4:0] OFF_MODE = 5'h00;
  localparam logic [4:0] OFF_CTRL = 5'h04;
  localparam logic [4:0] OFF_STAT = 5'h08;
  localparam logic [4:0] OFF_RXD  = 5'h0c;
  localparam logic [4:0] OFF_TXD  = 5'h10;
  localparam logic [4:0] OFF_BAUD = 5'h14;
  localparam int         CH_SEL   = 5;
  localparam int         GLB_SEL  = 6;
  localparam logic [4:0] OFF_IST  = 5'h00;
  localparam logic [4:0] OFF_ICLR = 5'h04;
  localparam logic [4:0] OFF_IEN  = 5'h08;
  // Mode register fields
  localparam int MD_MODE = 0;
  localparam int MD_SRC  = 2;
  localparam int MD_SCKO = 4;
  localparam int MD_SOE  = 5;
  // Control register fields
  localparam int CT_PEN  = 0;
  localparam int CT_PODD = 1;
  localparam int CT_STP2 = 2;
  localparam int CT_BIT8 = 3;
  localparam int CT_AD   = 4;
  localparam int CT_ECLR = 5;
  localparam int CT_TXE  = 6;
  localparam int CT_RXE  = 7;
  // Status register fields
  localparam int ST_TXE  = 0;
  localparam int ST_RXF  = 1;
  localparam int ST_PE   = 2;
  localparam int ST_ORE  = 3;
  localparam int ST_FRE  = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_MSB  = 6;
  localparam int ST_TIE  = 7;
  localparam int ST_RIE  = 8;
  // Interrupt bits per channel: rx done, rx error, tx done
  localparam int IRQ_PER = 3;
  localparam int IRQ_W   = 6;
  // Reset values
  localparam logic [5:0]  MODE_RST = 6'h00;
  localparam logic [7:0]  CTRL_RST = 8'h08;
  localparam logic [2:0]  BAUD_RST = 3'h0;
  // Baud generator: 16 ticks per bit, divisor base shifted by setting
  localparam logic [15:0] BRG_BASE = 16'h000d;
  localparam logic [3:0]  PH_LAST  = 4'hf;
  localparam logic [3:0]  PH_MID   = 4'h8;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_MULTI, MODE_SYNC, MODE_RSVD} mode_t;
  typedef enum logic [1:0] {SRC_BRG, SRC_EXT, SRC_TIMER, SRC_NONE} src_t;
  typedef enum {RX_IDLE, RX_RUN} rx_state_t;
endpackage

// ### hdl/uart_ch_if.sv
`timescale 1ns/100ps
`default_nettype none
interface uart_ch_if;
  import uart_pkg::*;
  logic tick, eight, par_en, par_odd, two_stop, msb_first, rx_en;
  mode_t mode;
  logic tx_start, tx_ad, tx_busy, tx_done, sout, sck_lvl, sync_smp;
  logic [7:0] tx_data, rx_data;
  logic sin, rx_ad, rx_perr, rx_ferr, rx_done;
  modport ctl (output tick, eight, par_en, par_odd, two_stop, msb_first, rx_en, mode,
               tx_start, tx_ad, tx_data, sin,
               input tx_busy, tx_done, sout, sck_lvl, rx_data, rx_ad, rx_perr, rx_ferr,
               rx_done);
  modport tx (input tick, eight, par_en, par_odd, two_stop, msb_first, mode, tx_start,
              tx_ad, tx_data, output tx_busy, tx_done, sout, sck_lvl, sync_smp);
  modport rx (input tick, eight, par_en, par_odd, msb_first, rx_en, mode, sin, sync_smp,
              output rx_data, rx_ad, rx_perr, rx_ferr, rx_done);
endinterface // uart_ch_if
`default_nettype wire

// ### hdl/uart_tx.sv
`timescale 1ns/100ps
`default_nettype none
module uart_tx (
  input wire logic hclk,
  input wire logic hresetn,
  uart_ch_if.tx    ch
);
  import uart_pkg::*;
  logic [11:0] frame_reg, frame_next;
  logic [3:0]  left_reg, len_next, ph_reg;
  logic        busy_reg, eff8, has_x, xbit, par, sync;
  logic [7:0]  ord, rev;

  // 7 bits only in normal mode
  assign eff8 = ch.eight | (ch.mode != MODE_NORMAL);
  assign sync = (ch.mode == MODE_SYNC);
  assign rev  = {<<{ch.tx_data}};

  always_comb begin
    par = ^(eff8 ? ch.tx_data : {1'b0, ch.tx_data[6:0]}) ^ ch.par_odd;
    ord = ch.tx_data;
    if (ch.msb_first) begin
      ord = eff8 ? rev : {1'b0, rev[7:1]};
    end
    has_x = (ch.mode == MODE_MULTI) | ((ch.mode == MODE_NORMAL) & ch.par_en);
    xbit  = (ch.mode == MODE_MULTI) ? ch.tx_ad : par;
    if (sync) begin
      frame_next = {4'hf, ord};
      len_next   = 4'd8;
    end else if (eff8) begin
      frame_next = {2'b11, ~has_x | xbit, ord, 1'b0};
      len_next   = 4'd10 + {3'b0, has_x} + {3'b0, ch.two_stop};
    end else begin
      frame_next = {3'b111, ~has_x | xbit, ord[6:0], 1'b0};
      len_next   = 4'd9 + {3'b0, has_x} + {3'b0, ch.two_stop};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_reg  <= 1'b0;
      frame_reg <= 12'hfff;
      left_reg  <= 4'h0;
      ph_reg    <= 4'h0;
    end else if (!busy_reg) begin
      if (ch.tx_start) begin
        busy_reg  <= 1'b1;
        frame_reg <= frame_next;
        left_reg  <= len_next;
        ph_reg    <= 4'h0;
      end
    end else if (ch.tick) begin
      ph_reg <= ph_reg + 4'h1;
      if (ph_reg == PH_LAST) begin
        frame_reg <= {1'b1, frame_reg[11:1]};
        left_reg  <= left_reg - 4'h1;
        if (left_reg == 4'h1) begin
          busy_reg <= 1'b0;
        end
      end
    end
  end

  assign ch.tx_busy  = busy_reg;
  assign ch.tx_done  = busy_reg & ch.tick & (ph_reg == PH_LAST) & (left_reg == 4'h1);
  assign ch.sout     = ~busy_reg | frame_reg[0];
  assign ch.sck_lvl  = ~(busy_reg & sync) | ph_reg[3];
  assign ch.sync_smp = busy_reg & sync & ch.tick & (ph_reg == PH_MID - 4'h1);
endmodule // uart_tx
`default_nettype wire

// ### hdl/uart_rx.sv
`timescale 1ns/100ps
`default_nettype none
module uart_rx (
  input wire logic hclk,
  input wire logic hresetn,
  uart_ch_if.rx    ch
);
  import uart_pkg::*;
  rx_state_t  state_reg;
  logic [3:0] ph_reg, k_reg, nlast;
  logic [7:0] dbuf_reg;
  logic [2:0] didx, pos;
  logic       x_reg, eff8, sync, has_x, smp, done_reg, perr_reg, ferr_reg;

  assign eff8  = ch.eight | (ch.mode != MODE_NORMAL);
  assign sync  = (ch.mode == MODE_SYNC);
  assign has_x = (ch.mode == MODE_MULTI) | ((ch.mode == MODE_NORMAL) & ch.par_en);
  assign nlast = eff8 ? 4'd8 : 4'd7;
  assign didx  = sync ? k_reg[2:0] : k_reg[2:0] - 3'd1;
  assign pos   = ch.msb_first ? (eff8 ? 3'd7 : 3'd6) - didx : didx;
  assign smp   = ch.tick & (ph_reg == PH_MID);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= RX_IDLE;
      ph_reg    <= 4'h0;
      k_reg     <= 4'h0;
      dbuf_reg  <= 8'h00;
      x_reg     <= 1'b0;
      done_reg  <= 1'b0;
      perr_reg  <= 1'b0;
      ferr_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!ch.rx_en) begin
        state_reg <= RX_IDLE;
        k_reg     <= 4'h0;
      end else if (sync) begin
        if (ch.sync_smp) begin
          dbuf_reg[pos] <= ch.sin;
          k_reg         <= (k_reg == 4'd7) ? 4'h0 : k_reg + 4'h1;
          done_reg      <= (k_reg == 4'd7);
          perr_reg      <= 1'b0;
          ferr_reg      <= 1'b0;
        end
      end else if (state_reg == RX_IDLE) begin
        if (ch.tick & ~ch.sin) begin
          state_reg <= RX_RUN;
          ph_reg    <= 4'h1;
          k_reg     <= 4'h0;
          dbuf_reg  <= 8'h00;
        end
      end else if (ch.tick) begin
        ph_reg <= ph_reg + 4'h1;
        if (smp) begin
          k_reg <= k_reg + 4'h1;
          if (k_reg == 4'h0) begin
            if (ch.sin) begin
              state_reg <= RX_IDLE;
            end
          end else if (k_reg <= nlast) begin
            dbuf_reg[pos] <= ch.sin;
          end else if (has_x & (k_reg == nlast + 4'h1)) begin
            x_reg <= ch.sin;
          end else begin
            state_reg <= RX_IDLE;
            done_reg  <= 1'b1;
            ferr_reg  <= ~ch.sin;
            perr_reg  <= (ch.mode == MODE_NORMAL) & ch.par_en &
                         (^dbuf_reg ^ ch.par_odd ^ x_reg);
          end
        end
      end
    end
  end

  assign ch.rx_data = dbuf_reg;
  assign ch.rx_ad   = x_reg & (ch.mode == MODE_MULTI);
  assign ch.rx_done = done_reg;
  assign ch.rx_perr = perr_reg;
  assign ch.rx_ferr = ferr_reg;
endmodule // uart_rx
`default_nettype wire

// ### testbench/uart_serial_datapath_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module uart_serial_datapath_assertions (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        irq,
  input wire logic        serial_out_pin_a,
  input wire logic        serial_out_oe_n_a,
  input wire logic        serial_out_oe_n_b,
  input wire logic        serial_clock_pin_a_oe_n
);
  logic       wr_q;
  logic       rd_q;
  logic [6:0] adr_q;
  // Data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      adr_q <= 7'h00;
    end else begin
      wr_q  <= hsel & htrans[1] & hready & hwrite;
      rd_q  <= hsel & htrans[1] & hready & ~hwrite;
      adr_q <= haddr[6:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////
  property p_hold_a;
    !$stable(serial_out_pin_a) |=> $stable(serial_out_pin_a) [*7];
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("serial bit too short");
  property p_oe_a;
    wr_q && adr_q == 7'h00 |=> serial_out_oe_n_a == !$past(hwdata[5]);
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("out enable a wrong");
  property p_sck_oe_a;
    wr_q && adr_q == 7'h00 |=> serial_clock_pin_a_oe_n == !$past(hwdata[4]);
  endproperty
  a_sck_oe_a: assert property (p_sck_oe_a) else $error("clock pin dir a wrong");
  property p_oe_b;
    wr_q && adr_q == 7'h20 |=> serial_out_oe_n_b == !$past(hwdata[5]);
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("out enable b wrong");
  property p_irq_off;
    wr_q && adr_q == 7'h48 && hwdata[5:0] == 6'h00 |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all disabled");
  property p_unmapped;
    rd_q && adr_q == 7'h18 |-> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_resp;
    hresp == 1'b0;
  endproperty
  a_resp: assert property (p_resp) else $error("response not okay");
  property p_ready;
    hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
endmodule // uart_serial_datapath_assertions
bind uart_serial_datapath uart_serial_datapath_assertions u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .irq(irq), .serial_out_pin_a(serial_out_pin_a),
  .serial_out_oe_n_a(serial_out_oe_n_a), .serial_out_oe_n_b(serial_out_oe_n_b),
  .serial_clock_pin_a_oe_n(serial_clock_pin_a_oe_n));
`default_nettype wire

// ### testbench/serial_station_model.sv
`timescale 1ns/100ps
`default_nettype none
module serial_station_model #(parameter int BIT_NS = 1040) (
  input  wire logic line_in,
  output logic      line_out
);
  logic [11:0] got;
  initial line_out = 1'b1;
  task automatic send(input logic [8:0] d, input int n);
    line_out = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < n; i++) begin
      line_out = d[i];
      #(BIT_NS);
    end
    line_out = 1'b1;
    #(BIT_NS);
  endtask
  // Mid-bit sampling from start edge
  task automatic recv(input int n);
    got = '1;
    @(negedge line_in);
    #(BIT_NS / 2);
    for (int i = 0; i < n; i++) begin
      got[i] = line_in;
      #(BIT_NS);
    end
  endtask
endmodule // serial_station_model
`default_nettype wire

// ### testbench/uart_serial_datapath_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module uart_serial_datapath_tb_top;
  logic        hclk, hresetn, hwrite, irq, hreadyout, tick_b, sout_a, sout_b, sin_b, sck_a;
  logic [1:0]  htrans;
  logic [3:0]  tcnt;
  logic [31:0] haddr, hwdata, hrdata, rv;
  int          err_count, n_compared;
  int          sck_falls = 0;

  uart_serial_datapath DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .irq(irq),
    .timer_tick_a(1'b0), .timer_tick_b(tick_b), .serial_in_pin_a(sout_b),
    .serial_in_pin_b(sin_b), .serial_out_pin_a(sout_a), .serial_out_pin_b(sout_b),
    .serial_out_oe_n_a(), .serial_out_oe_n_b(), .serial_clock_pin_a_in(1'b0),
    .serial_clock_pin_b_in(1'b0), .serial_clock_pin_a_out(sck_a), .serial_clock_pin_b_out(),
    .serial_clock_pin_a_oe_n(), .serial_clock_pin_b_oe_n());
  serial_station_model u_peer (.line_in(sout_a), .line_out(sin_b));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (!hresetn) begin
      tcnt   <= 4'd0;
      tick_b <= 1'b0;
    end else begin
      tcnt   <= (tcnt == 4'd12) ? 4'd0 : tcnt + 4'd1;
      tick_b <= (tcnt == 4'd12);
    end
  end
  always @(negedge sck_a) begin
    sck_falls++;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ahb(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'b10;
    haddr  <= {25'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wait_int(input logic [5:0] m);
    for (int i = 0; i < 3000; i++) begin
      ahb(1'b0, 7'h40, 32'h0);
      if ((rv[5:0] & m) == m) break;
    end
    chk("int_status", rv & {26'h0, m}, {26'h0, m});
  endtask
  task automatic tx_frame(input logic [7:0] ctl, st, d, input int n);
    ahb(1'b1, 7'h04, {24'h0, ctl});
    ahb(1'b1, 7'h08, {24'h0, st});
    fork
      u_peer.recv(n);
      ahb(1'b1, 7'h10, {24'h0, d});
    join
    wait_int(6'h04);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    ahb(1'b0, 7'h00, 32'h0);
    chk("mode_a", rv, 32'h0);
    ahb(1'b0, 7'h04, 32'h0);
    chk("ctrl_a", rv, 32'h08);
    ahb(1'b0, 7'h08, 32'h0);
    chk("stat_a", rv, 32'h01);
    ahb(1'b0, 7'h18, 32'h0);
    chk("unmapped", rv, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_tx_plain;
    ahb(1'b1, 7'h48, 32'h04);
    ahb(1'b1, 7'h00, 32'h30);
    tx_frame(8'h48, 8'h80, 8'ha5, 10);
    chk("frame", {20'h0, u_peer.got}, {20'h0, 3'b111, 8'ha5, 1'b0});
    @(negedge hclk);
    chk("irq_set", {31'h0, irq}, 32'h1);
    ahb(1'b1, 7'h44, 32'h04);
    @(negedge hclk);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    ahb(1'b1, 7'h48, 32'h00);
    $display("t_tx_plain done");
  endtask
  task automatic t_tx_parity;
    tx_frame(8'h4f, 8'h80, 8'h5a, 12);
    chk("par_frame", {20'h0, u_peer.got}, {20'h0, 2'b11, ~^8'h5a, 8'h5a, 1'b0});
    ahb(1'b1, 7'h44, 32'h3f);
    $display("t_tx_parity done");
  endtask
  task automatic t_tx_msb;
    tx_frame(8'h48, 8'hc0, 8'h01, 10);
    chk("msb_frame", {20'h0, u_peer.got}, {20'h0, 3'b111, 8'h80, 1'b0});
    ahb(1'b1, 7'h44, 32'h3f);
    $display("t_tx_msb done");
  endtask
  task automatic t_tx_seven;
    tx_frame(8'h40, 8'h80, 8'h80, 9);
    chk("seven_frame", {20'h0, u_peer.got}, {20'h0, 4'hf, 7'h00, 1'b0});
    ahb(1'b1, 7'h44, 32'h3f);
    $display("t_tx_seven done");
  endtask
  task automatic t_tx_sync;
    ahb(1'b1, 7'h00, 32'h32);
    tx_frame(8'h48, 8'h80, 8'h5a, 8);
    chk("sync_frame", {20'h0, u_peer.got}, {20'h0, 4'hf, 8'h5a});
    chk("sck_falls", sck_falls, 32'd8);
    ahb(1'b1, 7'h00, 32'h30);
    ahb(1'b1, 7'h44, 32'h3f);
    $display("t_tx_sync done");
  endtask
  task automatic t_rx;
    ahb(1'b1, 7'h20, 32'h08);
    ahb(1'b1, 7'h24, 32'h89);
    ahb(1'b1, 7'h28, 32'h100);
    u_peer.send({^8'h3c, 8'h3c}, 9);
    wait_int(6'h08);
    ahb(1'b0, 7'h2c, 32'h0);
    chk("rx_data", rv & 32'hff, 32'h3c);
    ahb(1'b0, 7'h28, 32'h0);
    chk("rx_ok", rv & 32'h1c, 32'h0);
    ahb(1'b1, 7'h44, 32'h3f);
    u_peer.send({~^8'hc3, 8'hc3}, 9);
    wait_int(6'h08);
    ahb(1'b0, 7'h28, 32'h0);
    chk("par_err", rv & 32'h1c, 32'h04);
    ahb(1'b1, 7'h44, 32'h3f);
    u_peer.send({^8'h11, 8'h11}, 9);
    wait_int(6'h08);
    ahb(1'b0, 7'h28, 32'h0);
    chk("ovr_err", rv & 32'h08, 32'h08);
    ahb(1'b1, 7'h24, 32'ha9);
    ahb(1'b0, 7'h28, 32'h0);
    chk("err_clr", rv & 32'h1c, 32'h0);
    ahb(1'b1, 7'h20, 32'h09);
    ahb(1'b1, 7'h44, 32'h3f);
    u_peer.send({1'b1, 8'h03}, 9);
    wait_int(6'h08);
    ahb(1'b0, 7'h2c, 32'h0);
    chk("ad_bit", rv & 32'h1ff, 32'h103);
    ahb(1'b0, 7'h28, 32'h0);
    chk("multi_no_par", rv & 32'h04, 32'h0);
    $display("t_rx done");
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #200000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata} = '0;
    err_count = 0;
    n_compared = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_tx_plain;
    t_tx_parity;
    t_tx_msb;
    t_tx_seven;
    t_tx_sync;
    t_rx;
    tally_and_finish;
  end
endmodule // uart_serial_datapath_tb_top
`default_nettype wire
